// ---- include/gpp_pkg.sv ----
// Operation
// - Drive-enable bit one makes pin output
// - Enable set alias sets only chosen bits
// - Value set alias sets chosen value bits
// - Value clear alias clears chosen value bits
// - Toggle alias or level write inverts value
// - Enable clear alias makes chosen pins inputs
// - Enable toggle alias reverses pin direction
// - Pin level synchronised before sampled register
// - Input-off stops synchroniser, level invalid
// - Sampled level reflects pad both directions
// - Reset leaves outputs tri-stated, inputs on
// - Polarity flip inverts driven and sensed value
// - Polarity change makes edge on internal signal
// - Weak high bias bit enables pull-up
// - Sense config picks interrupt condition
// - Flip with sense change may skip interrupt
// - Pending interrupt may fire on re-enable
// - Sense change may drop pending interrupt
// - Wake: async any, others dual/level only
// - Pin config at base plus 0x10 plus n
// - Alias write equals regular register write
// - At most eight pins per port
// - Request holds while flag set and enabled
// - Event output is pin value, zero if off
// - Synchronous sense dead time three cycles
`default_nettype none
package gpp_pkg;
    localparam int          NPIN = 8;
    localparam logic [5:0] OFS_DIR      = 6'h00;
    localparam logic [5:0] OFS_EN_SET   = 6'h01;
    localparam logic [5:0] OFS_EN_CLR   = 6'h02;
    localparam logic [5:0] OFS_EN_TGL   = 6'h03;
    localparam logic [5:0] OFS_OUT      = 6'h04;
    localparam logic [5:0] OFS_VAL_SET  = 6'h05;
    localparam logic [5:0] OFS_VAL_CLR  = 6'h06;
    localparam logic [5:0] OFS_VAL_TGL  = 6'h07;
    localparam logic [5:0] OFS_IN       = 6'h08;
    localparam logic [5:0] OFS_FLAGS    = 6'h09;
    localparam logic [5:0] OFS_PINCFG   = 6'h10;
    // Whole-byte alias window for direction, value, input and flags
    localparam logic [5:0] OFS_VDIR     = 6'h20;
    localparam logic [5:0] OFS_VOUT     = 6'h21;
    localparam logic [5:0] OFS_VIN      = 6'h22;
    localparam logic [5:0] OFS_VFLAGS   = 6'h23;
    localparam int          POS_FLIP    = 7;
    localparam int          POS_BIAS    = 3;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam int          DEAD_CYCLES = 3;
    typedef enum logic [2:0] {
        GPP_DUAL    = 3'b000,
        GPP_RISE    = 3'b001,
        GPP_FALL    = 3'b010,
        GPP_OFF     = 3'b011,
        GPP_LOW     = 3'b100
    } gpp_sense_t;
endpackage : gpp_pkg
`default_nettype wire

// ---- src/gpp_pin.sv ----
`timescale 1ns/100ps
`default_nettype none
// One pin: synchroniser, sensing, dead time
module gpp_pin
    import gpp_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    // Pad and configuration
    input  wire logic       pad_in,
    input  wire logic       flip,
    input  wire logic [2:0] sense,
    input  wire logic       async_cap,
    // Results
    output logic            level,
    output logic            hit,
    output logic            wake
);
    logic       s1_reg;
    logic       s2_reg;
    logic       prev_reg;
    logic [1:0] dead_reg;
    logic [1:0] dead_next;
    logic       off;
    logic       cur;
    logic       rise_w;
    logic       fall_w;
    logic       cond;

    assign off = (sense == GPP_OFF);
    assign cur = s2_reg ^ flip;
    assign level = off ? 1'b0 : cur;
    assign rise_w = cur & ~prev_reg;
    assign fall_w = ~cur & prev_reg;
    assign cond = (sense == GPP_DUAL) ? (rise_w | fall_w) :
                  (sense == GPP_RISE) ? rise_w :
                  (sense == GPP_FALL) ? fall_w :
                  (sense == GPP_LOW)  ? ~cur : 1'b0;
    assign hit = cond & (dead_reg == 2'd0);
    assign wake = hit & (async_cap | sense == GPP_DUAL | sense == GPP_LOW);
    assign dead_next = hit ? 2'(DEAD_CYCLES - 1) :
                       (dead_reg != 2'd0) ? dead_reg - 2'd1 : 2'd0;

    // Synchroniser halts while input is off to save power
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end else if (!off) begin
            s1_reg <= pad_in;
            s2_reg <= s1_reg;
        end
    end

    // Edge reference follows even when off; a stale edge may fire later
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prev_reg <= 1'b0;
            dead_reg <= 2'd0;
        end else begin
            prev_reg <= cur;
            dead_reg <= dead_next;
        end
    end
endmodule : gpp_pin
`default_nettype wire

// ---- src/gpp_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module gpp_port
    import gpp_pkg::*;
#(
    parameter logic [7:0] ASYNC_PINS = 8'h04
)(
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    // Register port
    input  wire logic [5:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // Pads
    input  wire logic [gpp_pkg::NPIN-1:0] pad_i,
    output logic      [gpp_pkg::NPIN-1:0] pad_o,
    output logic      [gpp_pkg::NPIN-1:0] pad_oe,
    output logic      [gpp_pkg::NPIN-1:0] pad_pullup,
    output logic      [gpp_pkg::NPIN-1:0] pad_in_en,
    // System side
    output logic      [gpp_pkg::NPIN-1:0] pin_event,
    output logic                      irq,
    output logic                      wake_req
);
    import gpp_pkg::*;

    // ************************************************
    // Registers and decode
    // ************************************************
    logic [7:0] dir_reg;
    logic [7:0] dir_next;
    logic [7:0] out_reg;
    logic [7:0] out_next;
    logic [7:0] flag_reg;
    logic [7:0] flag_next;
    logic [7:0] cfg_reg [NPIN];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] level_w;
    logic [7:0] hit_w;
    logic [7:0] wake_w;
    logic [7:0] flip_w;
    logic [7:0] in_en_w;
    logic       wr_dir;
    logic       wr_dset;
    logic       wr_dclr;
    logic       wr_dtgl;
    logic       wr_out;
    logic       wr_oset;
    logic       wr_oclr;
    logic       wr_otgl;
    logic       wr_flag;
    logic       cfg_sel;
    logic [2:0] cfg_idx;

    assign wr_dir  = reg_wr & (reg_addr == OFS_DIR | reg_addr == OFS_VDIR);
    assign wr_dset = reg_wr & (reg_addr == OFS_EN_SET);
    assign wr_dclr = reg_wr & (reg_addr == OFS_EN_CLR);
    assign wr_dtgl = reg_wr & (reg_addr == OFS_EN_TGL);
    assign wr_out  = reg_wr & (reg_addr == OFS_OUT | reg_addr == OFS_VOUT);
    assign wr_oset = reg_wr & (reg_addr == OFS_VAL_SET);
    assign wr_oclr = reg_wr & (reg_addr == OFS_VAL_CLR);
    assign wr_otgl = reg_wr & (reg_addr == OFS_VAL_TGL | reg_addr == OFS_IN |
                               reg_addr == OFS_VIN);
    assign wr_flag = reg_wr & (reg_addr == OFS_FLAGS |
                               reg_addr == OFS_VFLAGS);
    assign cfg_sel = (reg_addr[5:3] == OFS_PINCFG[5:3]);
    assign cfg_idx = reg_addr[2:0];

    // ************************************************
    // Next-state logic
    // ************************************************
    always_comb begin
        dir_next = dir_reg;
        if (wr_dir)
            dir_next = reg_wdata;
        else if (wr_dset)
            dir_next = dir_reg | reg_wdata;
        else if (wr_dclr)
            dir_next = dir_reg & ~reg_wdata;
        else if (wr_dtgl)
            dir_next = dir_reg ^ reg_wdata;
    end

    always_comb begin
        out_next = out_reg;
        if (wr_out)
            out_next = reg_wdata;
        else if (wr_oset)
            out_next = out_reg | reg_wdata;
        else if (wr_oclr)
            out_next = out_reg & ~reg_wdata;
        else if (wr_otgl)
            out_next = out_reg ^ reg_wdata;
    end

    // Write one clears; a new hit in the same cycle wins
    assign flag_next = (flag_reg & ~(wr_flag ? reg_wdata : 8'h00)) | hit_w;

    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            if (cfg_sel)
                rdata_next = cfg_reg[cfg_idx];
            else begin
                case (reg_addr)
                    OFS_DIR, OFS_VDIR:     rdata_next = dir_reg;
                    OFS_OUT, OFS_VOUT:     rdata_next = out_reg;
                    OFS_IN, OFS_VIN:       rdata_next = level_w;
                    OFS_FLAGS, OFS_VFLAGS: rdata_next = flag_reg;
                    default:               rdata_next = 8'h00;
                endcase
            end
        end
    end

    // ************************************************
    // State
    // ************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dir_reg   <= RST_BYTE;
            out_reg   <= RST_BYTE;
            flag_reg  <= 8'h00;
            rdata_reg <= 8'h00;
        end else begin
            dir_reg   <= dir_next;
            out_reg   <= out_next;
            flag_reg  <= flag_next;
            rdata_reg <= rdata_next;
        end
    end

    // ************************************************
    // Per-pin configuration and sensing
    // ************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn)
                    cfg_reg[gi] <= RST_BYTE;
                else if (reg_wr && cfg_sel && cfg_idx == 3'(gi))
                    cfg_reg[gi] <= reg_wdata;
            end

            assign flip_w[gi]  = cfg_reg[gi][POS_FLIP];
            assign in_en_w[gi] = (cfg_reg[gi][2:0] != GPP_OFF);
            assign pad_pullup[gi] = cfg_reg[gi][POS_BIAS];

            gpp_pin u_pin (
                .sys_clk   (sys_clk),
                .rstn      (rstn),
                .pad_in    (pad_i[gi]),
                .flip      (flip_w[gi]),
                .sense     (cfg_reg[gi][2:0]),
                .async_cap (ASYNC_PINS[gi]),
                .level     (level_w[gi]),
                .hit       (hit_w[gi]),
                .wake      (wake_w[gi])
            );
        end
    endgenerate

    // ************************************************
    // Outputs
    // ************************************************
    assign pad_o     = out_reg ^ flip_w;
    assign pad_oe    = dir_reg;
    assign pad_in_en = in_en_w;
    assign pin_event = level_w;
    assign irq       = |(flag_reg & in_en_w);
    assign wake_req  = |wake_w;
    assign reg_rdata = rdata_reg;
endmodule : gpp_port
`default_nettype wire

// ---- bench/gpp_pad_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module gpp_pad_model (
    // Clock
    input  wire logic       sys_clk,
    // Port side
    input  wire logic [7:0] pad_o,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pullup,
    // Outside drivers
    input  wire logic [7:0] ext_drv,
    input  wire logic [7:0] ext_en,
    output logic      [7:0] pad_lvl
);
    logic flt_reg = 1'b0;
    // Undriven line without pull-up wanders, so a stale level never reads as valid
    always_ff @(posedge sys_clk) flt_reg <= ~flt_reg;
    assign pad_lvl = (pad_oe & pad_o) | (~pad_oe & ext_en & ext_drv)
        | (~pad_oe & ~ext_en & (pad_pullup | {8{flt_reg}}));
endmodule : gpp_pad_model
`default_nettype wire

// ---- bench/gpp_port_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module gpp_port_props
    import gpp_pkg::*;
#(parameter logic [7:0] ASYNC_PINS = 8'h04)(
    // Clock and register port
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pads and system side
    input wire logic [7:0] pad_i,
    input wire logic [7:0] pad_o,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup,
    input wire logic [7:0] pad_in_en,
    input wire logic [7:0] pin_event,
    input wire logic       irq,
    input wire logic       wake_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire logic w_cfg = reg_wr && reg_addr[5:3] == 3'h2;
    wire logic [2:0] cfg_pin = reg_addr[2:0];
    wire logic w_dir = reg_wr && (reg_addr == 6'h00 || reg_addr == 6'h20);
    wire logic w_any = w_dir || (reg_wr && reg_addr[5:2] == 4'h0);
    a_dir_write: assert property (w_dir |=> pad_oe == $past(reg_wdata))
        else $error("dir write lost");
    a_drive_enable_set_alias_only: assert property (reg_wr && reg_addr == 6'h01
        |=> pad_oe == ($past(pad_oe) | $past(reg_wdata))) else $error("set");
    a_drive_enable_clear_alias_only: assert property (reg_wr && reg_addr == 6'h02
        |=> pad_oe == ($past(pad_oe) & ~$past(reg_wdata))) else $error("clr");
    a_drive_enable_toggle_alias_flip: assert property (reg_wr && reg_addr == 6'h03
        |=> pad_oe == ($past(pad_oe) ^ $past(reg_wdata))) else $error("tgl");
    a_oe_hold: assert property (!w_any |=> $stable(pad_oe))
        else $error("direction moved");
    a_event_off: assert property ((pin_event & ~pad_in_en) == 8'h00)
        else $error("event while off");
    a_bias_hold: assert property (!w_cfg |=> $stable(pad_pullup))
        else $error("pull-up moved");
    a_irq_holds: assert property (irq && !reg_wr |=> irq)
        else $error("request dropped");
    a_sense_off: assert property (w_cfg && reg_wdata[2:0] == 3'h3
        |=> !pad_in_en[$past(cfg_pin)]) else $error("input still on");
    a_wake_flags: assert property (wake_req && !reg_wr |=> irq)
        else $error("wake without request");
    c_irq: cover property (irq);
    c_wake: cover property (wake_req);
    c_tgl: cover property (reg_wr && reg_addr == 6'h03);
    c_off: cover property (pad_in_en != 8'hff);
endmodule : gpp_port_props
bind gpp_port gpp_port_props #(.ASYNC_PINS(ASYNC_PINS)) u_gpp_port_props (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .pad_in_en(pad_in_en),
    .pin_event(pin_event), .irq(irq), .wake_req(wake_req));
`default_nettype wire

// ---- bench/tb_gpp_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_gpp_port;
    import gpp_pkg::*;
    logic       sys_clk, rstn, reg_wr, reg_rd, irq, wake_req;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, pad_i, pad_o, pad_oe, pad_pullup;
    logic [7:0] pad_in_en, pin_event, ext_drv, ext_en;
    int         n_errors, total_checks;
    // Address, data, expected enables, expected drive values
    logic [29:0] rows [11] = '{{6'h00, 8'h0f, 8'h0f, 8'h00},
        {6'h01, 8'h30, 8'h3f, 8'h00}, {6'h02, 8'h05, 8'h3a, 8'h00},
        {6'h03, 8'hff, 8'hc5, 8'h00}, {6'h20, 8'h81, 8'h81, 8'h00},
        {6'h04, 8'haa, 8'h81, 8'haa}, {6'h05, 8'h05, 8'h81, 8'haf},
        {6'h06, 8'h0a, 8'h81, 8'ha5}, {6'h07, 8'hf0, 8'h81, 8'h55},
        {6'h08, 8'h03, 8'h81, 8'h56}, {6'h21, 8'h11, 8'h81, 8'h11}};
    gpp_sense_t codes [5] = '{GPP_DUAL, GPP_RISE, GPP_FALL, GPP_LOW, GPP_OFF};
    logic [4:0] fire = 5'b01011;
    logic [4:0] wakes = 5'b01001;
    int         nw;
    // Wake pulses last one cycle, so they are counted
    int         n_wake = 0;
    always @(posedge sys_clk) n_wake <= n_wake + int'(wake_req);
    gpp_port u_gpp_port (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .pad_in_en(pad_in_en),
        .pin_event(pin_event), .irq(irq), .wake_req(wake_req));
    gpp_pad_model u_gpp_pad_model (.sys_clk(sys_clk), .pad_o(pad_o),
        .pad_oe(pad_oe), .pad_pullup(pad_pullup), .ext_drv(ext_drv),
        .ext_en(ext_en), .pad_lvl(pad_i));
    // ****************
    // Tasks
    // ****************
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch t=%0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    // ****************
    // Stimulus
    // ****************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #1000000;
        n_errors++;
        finish_test();
    end
    initial begin
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        ext_drv = 8'h00;
        ext_en = 8'h00;
        n_errors = 0;
        total_checks = 0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        #1 chk(pad_oe, 8'h00);
        chk(pad_in_en, 8'hff);
        chk(pad_pullup, 8'h00);
        rd(6'h10, 8'h00);
        $display("done reset");
        foreach (rows[i]) begin
            wr(rows[i][29:24], rows[i][23:16]);
            chk(pad_oe, rows[i][15:8]);
            chk(pad_o, rows[i][7:0]);
        end
        $display("done table");
        ext_en <= 8'h7e;
        ext_drv <= 8'h24;
        repeat (5) @(posedge sys_clk);
        wr(6'h09, 8'hff);
        rd(6'h08, 8'h25);
        wr(6'h13, 8'h88);
        chk(pad_o, 8'h19);
        chk(pad_pullup, 8'h08);
        repeat (4) @(posedge sys_clk);
        rd(6'h09, 8'h08);
        rd(6'h08, 8'h2d);
        chk(pin_event, 8'h2d);
        rd(6'h13, 8'h88);
        rd(6'h0b, 8'h00);
        wr(6'h15, 8'h03);
        chk(pad_in_en, 8'hdf);
        repeat (3) @(posedge sys_clk);
        #1 chk(pin_event, 8'h0d);
        $display("done config");
        for (int k = 0; k < 5; k++) begin
            ext_drv[4] <= 1'b0;
            wr(6'h14, {5'h00, codes[k]});
            nw = n_wake;
            repeat (5) @(posedge sys_clk);
            wr(6'h09, 8'hff);
            ext_drv[4] <= 1'b1;
            repeat (6) @(posedge sys_clk);
            #1 chk({7'h00, irq}, {7'h00, fire[k]});
            chk({7'h00, n_wake != nw}, {7'h00, wakes[k]});
            rd(6'h09, {3'h0, fire[k], 4'h0});
        end
        // Pin 2 is wake-capable on any sense, even a single edge
        wr(6'h12, 8'h01);
        ext_drv[2] <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 nw = n_wake;
        ext_drv[2] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk({7'h00, n_wake != nw}, 8'h01);
        // Held low level fires once every three cycles
        ext_drv[4] <= 1'b0;
        wr(6'h14, {5'h00, GPP_LOW});
        repeat (3) @(posedge sys_clk);
        #1 nw = n_wake;
        repeat (9) @(posedge sys_clk);
        #1 chk(8'(n_wake - nw), 8'h03);
        $display("done sensing");
        finish_test();
    end
endmodule : tb_gpp_port
`default_nettype wire
